//--- src/nsp_top.sv
/*
  Sentence framer with serial port and once-per-second mark output.
  Assumes an APB master, a fix strobe and second mark from the solver.
*/
// Implementation choices: the APB interface to the registers and the address map.
// Notes on behaviour
// [RL1] Second mark pulse lasts one microsecond
// [RL2] Mark rises at GPS second when locked
// [RL3] Mark always produced, fix or not
// [RL4] Lock flag high only when aligned
// [RL5] Lost fixes: free-run, lock drops
// [RL6] Consecutive fixes realign and relock
// [RL7] Serial defaults 4800 baud, 8N1
// [RL8] Host matches baud and format
// [RL9] Two serial outputs, two serial inputs
// [RL10] Star plus two hex XOR digits
// [RL11] Dollar, header, commas, CR LF ending
// [RL12] Six sentence types supported
// [RL13] Position sentence field order kept
// [RL14] Status A valid, V warning
// [RL15] Mode N, D, A, E
// [RL16] Selection M manual, A automatic
// [RL17] Fix type 1, 2, 3
// [RL18] Twelve satellite slots, empty when unused
// [RL19] Dilution as two digits, point, digit
// [RL20] At most four satellites per sentence
// [RL21] Three leading counts in view sentence
// [RL22] Satellite numbering 01-32, 33-64
// [RL23] Elevation, azimuth, blank untracked noise
`timescale 1ns/1ns
module nsp_top #(
  parameter int unsigned SEC_CYCLES = nsp_pkg::SEC_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire nsp_pkg::nsp_apb_req_t apbReq,
  output nsp_pkg::nsp_apb_rsp_t      apbRsp,
  input  wire nsp_pkg::nsp_fix_t     gnssIn,
  input  wire logic                  serialInLogic,
  input  wire logic                  serialInLine,
  output logic                       serialOutLogic,
  output logic                       serialOutLine,
  output logic                       secondMarkPulse,
  output logic                       timingLockFlag
);
  import nsp_pkg::*;
  nsp_apb_rsp_t apbRsp_q;
  logic [2:0]   typeSel_q;
  logic         rxSel_q;
  logic [15:0]  baudDiv_q;
  nsp_field_t   field_q;
  logic [6:0]   bodyLen_q;
  logic [7:0]   body_q [BUF_DEPTH];
  nsp_seq_t     seq_q;
  logic [6:0]   idx_q;
  logic [7:0]   csum_q;
  logic [7:0]   ch;
  logic         charLoad;
  logic [9:0]   txShift_q;
  logic         txBusy_q;
  logic [3:0]   txBit_q;
  logic [15:0]  txCnt_q;
  logic         txOut_q;
  logic         rxBusy_q;
  logic [3:0]   rxBit_q;
  logic [15:0]  rxCnt_q;
  logic [7:0]   rxShift_q;
  logic [7:0]   rxData_q;
  logic         rxValid_q;
  logic         rxOver_q;
  logic         rxIn;
  logic         rxDone;
  logic [24:0]  phase_q;
  logic [24:0]  phase_d;
  logic         pps_q;
  logic         lock_q;
  logic [1:0]   consec_q;
  logic [1:0]   lost_q;
  logic         wrap;
  logic         realign;
  logic         setup;
  logic         wrEn;
  logic         rdPop;
  logic [31:0]  rdMux;
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == A_CTRL) || (a == A_STAT) || (a == A_FIELD) ||
             (a == A_LEN) || (a == A_RX) || (a == A_BAUD) ||
             (a >= A_BUF && a < A_BUFE && a[1:0] == 2'h0);
  endfunction : mapped
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hexChar
  function automatic logic [7:0] hdrChar(input logic [2:0] t,
                                         input logic [6:0] i);
    logic [23:0] name;
    name = T_FIX;
    case (t)
      3'h1: name = T_POS;
      3'h2: name = T_DOP;
      3'h3: name = T_VIEW;
      3'h4: name = T_MIN;
      3'h5: name = T_CRS;
      default: name = T_FIX;
    endcase
    case (i)
      7'h0: hdrChar = TALKER[15:8];
      7'h1: hdrChar = TALKER[7:0];
      7'h2: hdrChar = name[23:16];
      7'h3: hdrChar = name[15:8];
      default: hdrChar = name[7:0];
    endcase
  endfunction : hdrChar
  function automatic logic [7:0] encode(input logic [7:0] b,
                                        input nsp_field_t f);
    encode = b;
    if (b == TK_STATUS) begin
      encode = f.posValid ? 8'h41 : 8'h56; // RL14
    end else if (b == TK_MODE) begin
      case (f.mode) // RL15
        M_DIFF:  encode = 8'h44;
        M_AUTO:  encode = 8'h41;
        M_EST:   encode = 8'h45;
        default: encode = 8'h4E;
      endcase
    end else if (b == TK_SEL) begin
      encode = f.selAuto ? 8'h41 : 8'h4D; // RL16
    end else if (b == TK_FIX) begin
      encode = (f.fixType == 2'h2) ? 8'h32 :
               (f.fixType == 2'h3) ? 8'h33 : 8'h31; // RL17
    end
  endfunction : encode
  // APB slave, zero wait states; unmapped writes are dropped
  assign setup = apbReq.psel & ~apbReq.penable;
  assign wrEn  = apbReq.psel & apbReq.penable & apbRsp_q.pready &
                 apbReq.pwrite & ~apbRsp_q.pslverr;
  assign rdPop = apbReq.psel & apbReq.penable & apbRsp_q.pready &
                 ~apbReq.pwrite & (apbReq.paddr == A_RX);
  always_comb begin
    rdMux = 32'h0000_0000;
    if (apbReq.paddr == A_CTRL) begin
      rdMux = {27'h0, rxSel_q, typeSel_q, 1'b0};
    end else if (apbReq.paddr == A_STAT) begin
      rdMux = {28'h0, rxOver_q, rxValid_q, lock_q, seq_q != S_IDLE};
    end else if (apbReq.paddr == A_FIELD) begin
      rdMux = {26'h0, field_q};
    end else if (apbReq.paddr == A_LEN) begin
      rdMux = {25'h0, bodyLen_q};
    end else if (apbReq.paddr == A_RX) begin
      rdMux = {24'h0, rxData_q};
    end else if (apbReq.paddr == A_BAUD) begin
      rdMux = {16'h0, baudDiv_q};
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      apbRsp_q <= '0;
    end else begin
      apbRsp_q.pready <= setup;
      if (setup) begin
        apbRsp_q.pslverr <= ~mapped(apbReq.paddr);
        apbRsp_q.prdata  <= apbReq.pwrite ? 32'h0 : rdMux;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      typeSel_q <= 3'h0;
      rxSel_q   <= 1'b0;
      baudDiv_q <= BAUD_DIV; // RL7
      field_q   <= '0;
      bodyLen_q <= 7'h00;
    end else if (wrEn) begin
      if (apbReq.paddr == A_CTRL && seq_q == S_IDLE) begin
        typeSel_q <= apbReq.pwdata[C_TYPE +: 3]; // RL12
        rxSel_q   <= apbReq.pwdata[C_RXSEL];
      end else if (apbReq.paddr == A_FIELD) begin
        field_q <= apbReq.pwdata[5:0];
      end else if (apbReq.paddr == A_LEN) begin
        bodyLen_q <= apbReq.pwdata[6:0];
      end else if (apbReq.paddr == A_BAUD &&
                   apbReq.pwdata[15:0] != 16'h0) begin
        baudDiv_q <= apbReq.pwdata[15:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (wrEn && apbReq.paddr >= A_BUF && apbReq.paddr < A_BUFE) begin
      body_q[apbReq.paddr[7:2]] <= apbReq.pwdata[7:0];
    end
  end
  always_comb begin
    case (seq_q)
      S_DOLLAR: ch = CH_DOLLAR; // RL11
      S_HDR:    ch = hdrChar(typeSel_q, idx_q);
      S_BODY:   ch = encode(body_q[idx_q[5:0]], field_q); // RL13 RL18 RL19
      S_STAR:   ch = CH_STAR; // RL10
      S_HI:     ch = hexChar(csum_q[7:4]);
      S_LO:     ch = hexChar(csum_q[3:0]);
      S_CR:     ch = CH_CR;
      S_LF:     ch = CH_LF;
      default:  ch = 8'h00;
    endcase
  end
  assign charLoad = (seq_q != S_IDLE) && !txBusy_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      seq_q  <= S_IDLE;
      idx_q  <= 7'h00;
      csum_q <= 8'h00;
    end else if (seq_q == S_IDLE) begin
      if (wrEn && apbReq.paddr == A_CTRL && apbReq.pwdata[C_SEND]) begin
        seq_q  <= S_DOLLAR;
        csum_q <= 8'h00;
      end
    end else if (charLoad) begin
      case (seq_q)
        S_DOLLAR: begin
          seq_q <= S_HDR;
          idx_q <= 7'h00;
        end
        S_HDR: begin
          csum_q <= csum_q ^ ch; // RL10
          idx_q  <= idx_q + 7'h1;
          if (idx_q == 7'h4) begin
            idx_q <= 7'h00;
            seq_q <= (bodyLen_q == 7'h0) ? S_STAR : S_BODY;
          end
        end
        S_BODY: begin
          csum_q <= csum_q ^ ch; // RL10 RL20 RL21 RL22 RL23
          idx_q  <= idx_q + 7'h1;
          if (idx_q == bodyLen_q - 7'h1 || idx_q == 7'(BUF_DEPTH - 1)) begin
            seq_q <= S_STAR;
          end
        end
        S_STAR: seq_q <= S_HI;
        S_HI:   seq_q <= S_LO;
        S_LO:   seq_q <= S_CR;
        S_CR:   seq_q <= S_LF; // RL11
        default: seq_q <= S_IDLE;
      endcase
    end
  end
  // Serial transmitter, start, 8 data, stop, no parity
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txBusy_q  <= 1'b0;
      txShift_q <= 10'h3FF;
      txBit_q   <= 4'h0;
      txCnt_q   <= 16'h0000;
    end else if (charLoad) begin
      txBusy_q  <= 1'b1;
      txShift_q <= {1'b1, ch, 1'b0}; // RL7
      txBit_q   <= 4'h0;
      txCnt_q   <= 16'h0000;
    end else if (txBusy_q) begin
      txCnt_q <= txCnt_q + 16'h1;
      if (txCnt_q == baudDiv_q - 16'h1) begin
        txCnt_q   <= 16'h0000;
        txShift_q <= {1'b1, txShift_q[9:1]};
        txBit_q   <= txBit_q + 4'h1;
        if (txBit_q == 4'h9) begin
          txBusy_q <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txOut_q <= 1'b1;
    end else begin
      txOut_q <= txBusy_q ? txShift_q[0] : 1'b1; // RL9
    end
  end
  assign serialOutLogic = txOut_q;
  assign serialOutLine  = txOut_q;
  assign rxIn   = rxSel_q ? serialInLine : serialInLogic; // RL9
  assign rxDone = rxBusy_q && rxCnt_q == 16'h0 && rxBit_q == 4'h9 && rxIn;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxBusy_q  <= 1'b0;
      rxBit_q   <= 4'h0;
      rxCnt_q   <= 16'h0000;
      rxShift_q <= 8'h00;
    end else if (!rxBusy_q) begin
      if (!rxIn) begin
        rxBusy_q <= 1'b1;
        rxBit_q  <= 4'h0;
        rxCnt_q  <= {1'b0, baudDiv_q[15:1]};
      end
    end else if (rxCnt_q != 16'h0) begin
      rxCnt_q <= rxCnt_q - 16'h1;
    end else begin
      rxCnt_q <= baudDiv_q - 16'h1;
      rxBit_q <= rxBit_q + 4'h1;
      if (rxBit_q == 4'h0 && rxIn) begin
        rxBusy_q <= 1'b0;
      end else if (rxBit_q != 4'h0 && rxBit_q != 4'h9) begin
        rxShift_q <= {rxIn, rxShift_q[7:1]};
      end else if (rxBit_q == 4'h9) begin
        rxBusy_q <= 1'b0;
      end
    end
  end
  // Received byte; a new byte wins over a pop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxData_q  <= 8'h00;
      rxValid_q <= 1'b0;
      rxOver_q  <= 1'b0;
    end else begin
      if (rdPop) begin
        rxValid_q <= 1'b0;
        rxOver_q  <= 1'b0;
      end
      if (rxDone) begin
        rxData_q  <= rxShift_q;
        rxValid_q <= 1'b1;
        if (rxValid_q && !rdPop) begin
          rxOver_q <= 1'b1;
        end
      end
    end
  end
  assign wrap    = phase_q == 25'(SEC_CYCLES - 1);
  assign realign = gnssIn.secondMark && consec_q == FIX_NEED &&
                   phase_q >= 25'(PULSE_CYC); // RL2 RL6
  always_comb begin
    if (realign || wrap) begin
      phase_d = 25'h0;
    end else begin
      phase_d = phase_q + 25'h1; // RL3
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_q <= 25'h0;
      pps_q   <= 1'b1;
    end else begin
      phase_q <= phase_d;
      pps_q   <= phase_d < 25'(PULSE_CYC); // RL1
    end
  end
  assign secondMarkPulse = pps_q;
  // Fix tracking and lock flag; a lost fix wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      consec_q <= 2'h0;
      lost_q   <= 2'h0;
      lock_q   <= 1'b0;
    end else begin
      if (realign) begin
        lock_q <= 1'b1; // RL4 RL6
      end
      if (wrap && lost_q != LOST_SECS) begin
        lost_q <= lost_q + 2'h1;
      end
      if (gnssIn.fixStrobe && gnssIn.fixOk) begin
        lost_q <= 2'h0;
        if (consec_q != FIX_NEED) begin
          consec_q <= consec_q + 2'h1;
        end
      end else if (gnssIn.fixStrobe || lost_q == LOST_SECS) begin
        consec_q <= 2'h0; // RL5
        lock_q   <= 1'b0;
        lost_q   <= 2'h0;
      end
    end
  end
  assign timingLockFlag = lock_q;
  assign apbRsp         = apbRsp_q;
  chk_pulse_width: assert property (@(posedge clk) disable iff (!rstn) // RL1
    $rose(pps_q) |=> pps_q [*8] ##12 !pps_q)
    else $error("second mark width wrong");
  chk_realign_edge: assert property (@(posedge clk) disable iff (!rstn) // RL2
    realign |=> pps_q && phase_q == 25'h0 && $rose(pps_q))
    else $error("mark not at second start");
  chk_free_run: assert property (@(posedge clk) disable iff (!rstn) // RL3
    wrap && !realign |=> pps_q && phase_q == 25'h0)
    else $error("free-running mark missing");
  chk_lock_rise: assert property (@(posedge clk) disable iff (!rstn) // RL4
    $rose(lock_q) |-> $past(realign))
    else $error("lock raised without alignment");
  chk_lock_drop: assert property (@(posedge clk) disable iff (!rstn) // RL5
    gnssIn.fixStrobe && !gnssIn.fixOk |=> !lock_q && consec_q == 2'h0)
    else $error("lock kept after bad fix");
  chk_line_idle: assert property (@(posedge clk) disable iff (!rstn) // RL7
    !txBusy_q |=> serialOutLogic && serialOutLine)
    else $error("serial line not idle high");
  chk_check_hex: assert property (@(posedge clk) disable iff (!rstn) // RL10
    charLoad && seq_q == S_STAR |=> seq_q == S_HI &&
      ch inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("checksum digit wrong");
  chk_frame_end: assert property (@(posedge clk) disable iff (!rstn) // RL11
    charLoad && seq_q == S_CR |=> seq_q == S_LF && ch == CH_LF)
    else $error("sentence end wrong");
endmodule : nsp_top

//--- src/nsp_pkg.sv
/*
  Constants and types of the sentence framer and second mark block.
  Assumes a 20 MHz clock and an APB master with 32-bit data.
*/
package nsp_pkg;
  localparam int CLK_HZ    = 20_000_000;
  localparam int PULSE_NS  = 1000;
  localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SEC_CYC   = CLK_HZ;
  localparam int BAUD      = 4800;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD);
  localparam logic [1:0]  FIX_NEED = 2'h2;
  localparam logic [1:0]  LOST_SECS = 2'h2;
  localparam int BUF_DEPTH = 64;
  // Register byte addresses
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_STAT  = 12'h004;
  localparam logic [11:0] A_FIELD = 12'h008;
  localparam logic [11:0] A_LEN   = 12'h00C;
  localparam logic [11:0] A_RX    = 12'h010;
  localparam logic [11:0] A_BAUD  = 12'h014;
  localparam logic [11:0] A_BUF   = 12'h100;
  localparam logic [11:0] A_BUFE  = 12'h200;
  // Control field positions
  localparam int C_SEND = 0;
  localparam int C_TYPE = 1;
  localparam int C_RXSEL = 4;
  // Characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR   = 8'h2A;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_LF     = 8'h0A;
  localparam logic [15:0] TALKER   = 16'h4750;
  // Buffer tokens replaced by encoded fields
  localparam logic [7:0] TK_STATUS = 8'h01;
  localparam logic [7:0] TK_MODE   = 8'h02;
  localparam logic [7:0] TK_SEL    = 8'h03;
  localparam logic [7:0] TK_FIX    = 8'h04;
  // Sentence type mnemonics as ASCII
  localparam logic [23:0] T_FIX = 24'h474741;
  localparam logic [23:0] T_POS = 24'h474C4C;
  localparam logic [23:0] T_DOP = 24'h475341;
  localparam logic [23:0] T_VIEW = 24'h475356;
  localparam logic [23:0] T_MIN = 24'h524D43;
  localparam logic [23:0] T_CRS = 24'h565447;

  typedef enum logic [1:0] {M_INVALID, M_DIFF, M_AUTO, M_EST} nsp_mode_t;
  typedef enum {S_IDLE, S_DOLLAR, S_HDR, S_BODY, S_STAR, S_HI, S_LO,
                S_CR, S_LF} nsp_seq_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } nsp_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } nsp_apb_rsp_t;
  typedef struct packed {
    logic fixStrobe;
    logic fixOk;
    logic secondMark;
  } nsp_fix_t;
  typedef struct packed {
    logic      posValid;
    nsp_mode_t mode;
    logic      selAuto;
    logic [1:0] fixType;
  } nsp_field_t;
endpackage : nsp_pkg

//--- bench/nsp_host_model.sv
/*
  Host serial port model: decodes serial output, sends command bytes.
  Assumes both ends use the same bit time, in clock cycles.
*/
`timescale 1ns/1ns
module nsp_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] bitCyc,
  input  wire logic        txLogic,
  input  wire logic        txLine,
  input  wire logic        sendGo,
  input  wire logic        sendSel,
  input  wire logic [7:0]  sendByte,
  output logic             sendBusy,
  output logic             cmdLogic,
  output logic             cmdLine,
  output logic             rxStb,
  output logic [7:0]       rxByte,
  output logic             rxStop,
  output logic             linesSame
);
  logic [7:0] b;
  logic       same;
  logic [9:0] frame;

  // Receiver, same bit time and 8N1 format as the block
  initial begin
    rxStb = 1'b0;
    forever begin
      @(negedge clk);
      if (txLogic === 1'b0) begin
        same = 1'b1;
        repeat (bitCyc / 2) @(negedge clk);
        for (int i = 0; i < 9; i++) begin
          repeat (bitCyc) begin
            @(negedge clk);
            if (txLogic !== txLine) same = 1'b0;
          end
          if (i < 8) b[i] = txLogic;
        end
        rxByte <= b;
        rxStop <= txLogic;
        linesSame <= same;
        rxStb <= 1'b1;
        @(negedge clk);
        rxStb <= 1'b0;
      end
    end
  end

  // Transmitter, LSB first; unused input stays idle high
  initial begin
    cmdLogic = 1'b1;
    cmdLine = 1'b1;
    sendBusy = 1'b0;
    forever begin
      @(posedge clk);
      if (sendGo === 1'b1) begin
        sendBusy <= 1'b1;
        frame = {1'b1, sendByte, 1'b0};
        for (int j = 0; j < 10; j++) begin
          if (sendSel) cmdLine <= frame[j];
          else cmdLogic <= frame[j];
          repeat (bitCyc) @(posedge clk);
        end
        sendBusy <= 1'b0;
      end
    end
  end
endmodule : nsp_host_model

//--- bench/nsp_top_test.sv
/*
  Self-checking bench of the sentence framer and second mark block.
  Assumes the package and the host model are compiled first.
*/
`timescale 1ns/1ns
module nsp_top_test;
  import nsp_pkg::*;
  localparam int SECS = 200;
  logic         clk, rstn, sIn1, sIn2, sOut1, sOut2, pulse, lock;
  nsp_apb_req_t apbReq;
  nsp_apb_rsp_t apbRsp;
  nsp_fix_t     gnssIn;
  logic [15:0]  bitCyc;
  logic         sendGo, sendSel, sendBusy, rxStb, rxStop, linesSame;
  logic [7:0]   sendByte, rxByte, b;
  integer       seed;
  int           fails, nTests, t0, wid, armed;
  int           cyc = 0;
  logic [7:0]   serQ[$];
  logic [64:0]  apbQ[$];

  nsp_top #(.SEC_CYCLES(SECS)) uut (.clk(clk), .rstn(rstn),
    .apbReq(apbReq), .apbRsp(apbRsp), .gnssIn(gnssIn),
    .serialInLogic(sIn1), .serialInLine(sIn2), .serialOutLogic(sOut1),
    .serialOutLine(sOut2), .secondMarkPulse(pulse),
    .timingLockFlag(lock));
  nsp_host_model host (.clk(clk), .bitCyc(bitCyc), .txLogic(sOut1),
    .txLine(sOut2), .sendGo(sendGo), .sendSel(sendSel),
    .sendByte(sendByte), .sendBusy(sendBusy), .cmdLogic(sIn1),
    .cmdLine(sIn2), .rxStb(rxStb), .rxByte(rxByte), .rxStop(rxStop),
    .linesSame(linesSame));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic hang;
    fails++;
    $display("[ERR] wait expected done seen stuck");
    give_verdict();
  endtask : hang

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [64:0] note);
    int n;
    @(posedge clk);
    if (!w) apbQ.push_back(note);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (apbRsp.pready !== 1'b1) hang();
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 65'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] v, input logic e);
    apb(1'b0, a, 32'h0, {e, m, v});
  endtask : rd

  // Read results against the oldest note
  always @(negedge clk) begin
    logic [64:0] e;
    if (apbReq.psel && apbReq.penable && !apbReq.pwrite &&
        apbRsp.pready === 1'b1 && apbQ.size() > 0) begin
      e = apbQ.pop_front();
      check("prdata", apbRsp.prdata & e[63:32], e[31:0]);
      check("pslverr", apbRsp.pslverr, e[64]);
    end
  end

  // Serial characters against the oldest note
  always @(posedge rxStb) begin
    check("char queued", serQ.size() > 0, 1);
    if (serQ.size() > 0) check("char", rxByte, serQ.pop_front());
    check("stop bit", rxStop, 1);
    check("line copy", linesSame, 1);
  end

  // Width of each full mark pulse
  always @(negedge clk) begin
    if (rstn !== 1'b1) begin
      wid = 0;
      armed = 0;
    end else if (pulse === 1'b1) wid++;
    else begin
      if (armed && wid > 0) check("mark width", wid, PULSE_CYC);
      armed = 1;
      wid = 0;
    end
  end

  task automatic wait_rise;
    logic p;
    int   n;
    p = pulse;
    n = 0;
    do begin
      p = pulse;
      @(negedge clk);
      n++;
    end while (!(pulse === 1'b1 && p === 1'b0) && n < 3 * SECS);
    if (n >= 3 * SECS) hang();
  endtask : wait_rise

  task automatic fix(input logic ok);
    @(posedge clk);
    gnssIn.fixStrobe <= 1'b1;
    gnssIn.fixOk <= ok;
    @(posedge clk);
    gnssIn.fixStrobe <= 1'b0;
  endtask : fix

  task automatic mark;
    @(posedge clk);
    gnssIn.secondMark <= 1'b1;
    @(posedge clk);
    gnssIn.secondMark <= 1'b0;
    @(negedge clk);
    check("mark realigned", pulse, 1);
    check("lock on", lock, 1);
  endtask : mark

  function automatic logic [7:0] expand(input logic [7:0] c,
                                        input logic [5:0] f);
    string md = "NDAE";
    case (c)
      8'h01: return f[5] ? "A" : "V";
      8'h02: return md[f[4:3]];
      8'h03: return f[2] ? "A" : "M";
      8'h04: return f[1:0] == 2'h3 ? "3" : f[1:0] == 2'h2 ? "2" : "1";
      default: return c;
    endcase
  endfunction : expand

  task automatic sentence(input int ty, input int len, input logic [5:0] f);
    string      nm = "GGAGLLGSAGSVRMCVTG";
    string      hx = "0123456789ABCDEF";
    string      tn;
    logic [7:0] c, x, r;
    int         n;
    tn = {"GP", nm.substr(3 * ty, 3 * ty + 2)};
    serQ.push_back(8'h24);
    x = 8'h00;
    for (int k = 0; k < 5; k++) begin
      serQ.push_back(tn[k]);
      x ^= tn[k];
    end
    wr(A_FIELD, {26'h0, f});
    wr(A_LEN, 32'(len));
    for (int k = 0; k < len; k++) begin
      r = 8'(($random(seed) & 32'h7FFFFFFF) % 11);
      c = k < 4 ? 8'(k + 1) : (r == 8'h0A ? 8'h2C : 8'h30 + r);
      wr(A_BUF + 12'(4 * k), {24'h0, c});
      c = expand(c, f);
      serQ.push_back(c);
      x ^= c;
    end
    serQ.push_back(8'h2A);
    serQ.push_back(hx[x[7:4]]);
    serQ.push_back(hx[x[3:0]]);
    serQ.push_back(8'h0D);
    serQ.push_back(8'h0A);
    wr(A_CTRL, {28'h0, 3'(ty), 1'b1});
    wr(A_CTRL, {28'h0, 3'(ty + 1), 1'b1});
    n = 0;
    while (serQ.size() > 0 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (serQ.size() > 0) hang();
    rd(A_STAT, 32'h1, 32'h0, 1'b0);
  endtask : sentence

  task automatic host_send(input logic s, input logic [7:0] v);
    int n;
    @(posedge clk);
    sendSel <= s;
    sendByte <= v;
    sendGo <= 1'b1;
    @(posedge clk);
    sendGo <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sendBusy !== 1'b0 && n < 400);
    if (n >= 400) hang();
    repeat (4) @(posedge clk);
  endtask : host_send

  initial begin
    rstn = 1'b0;
    apbReq = '0;
    gnssIn = '0;
    sendGo = 1'b0;
    sendSel = 1'b0;
    sendByte = 8'h00;
    bitCyc = BAUD_DIV;
    seed = 81971;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("lock at reset", lock, 0);
    check("idle outputs", {sOut1, sOut2}, 2'h3);
    rd(A_BAUD, 32'hFFFF, 32'(BAUD_DIV), 1'b0);
    rd(12'h040, 32'hFFFFFFFF, 32'h0, 1'b1);
    rd(A_BUF, 32'hFFFFFFFF, 32'h0, 1'b0);
    wait_rise();
    t0 = cyc;
    wait_rise();
    check("free period", cyc - t0, SECS);
    fix(1'b1);
    fix(1'b1);
    @(negedge clk);
    check("lock before mark", lock, 0);
    repeat (20) @(posedge clk);
    mark();
    t0 = cyc;
    wait_rise();
    check("locked period", cyc - t0, SECS);
    fix(1'b0);
    @(negedge clk);
    check("lock after bad fix", lock, 0);
    wait_rise();
    fix(1'b1);
    fix(1'b1);
    repeat (20) @(posedge clk);
    mark();
    repeat (2 * SECS + 5) @(posedge clk);
    @(negedge clk);
    check("lock after silence", lock, 0);
    wr(A_BAUD, 32'h10);
    bitCyc <= 16'h0010;
    for (int i = 0; i < 7; i++)
      sentence(i % 6, i == 6 ? 0 : 4 + i, {i[0], i[1:0], i[1], i[1:0]});
    for (int s = 0; s < 2; s++) begin
      wr(A_CTRL, 32'(s) << 4);
      b = 8'($random(seed));
      host_send(s[0], b);
      rd(A_STAT, 32'h4, 32'h4, 1'b0);
      rd(A_RX, 32'hFF, {24'h0, b}, 1'b0);
      host_send(!s[0], ~b);
      rd(A_STAT, 32'h4, 32'h0, 1'b0);
    end
    give_verdict();
  end
endmodule : nsp_top_test
